// [hdl/cdic_pkg.sv]
// constants, types and helper functions for the cascaded interrupt controller
// assumes an 8-bit I/O port bus with 16-bit port addresses
package cdic_pkg;

   // ------------------------------------------------------------
   // port map
   // ------------------------------------------------------------
   localparam logic [15:0] MASTER_BASE = 16'h0020;
   localparam logic [15:0] SLAVE_BASE  = 16'h00A0;
   localparam logic        OFS_CMD     = 1'h0;
   localparam logic        OFS_DATA    = 1'h1;

   // ------------------------------------------------------------
   // command and field layout
   // ------------------------------------------------------------
   localparam int INIT_WORD_ONE_SEL_BIT  = 4;
   localparam int INIT_WORD_ONE_LTIM_BIT = 3;
   localparam int INIT_WORD_ONE_SNGL_BIT = 1;
   localparam int INIT_WORD_ONE_IC4_BIT  = 0;
   localparam int STATUS_SELECT_COMMAND_SEL_BIT  = 3;
   localparam int INIT_WORD_MODE_AEOI_BIT = 1;
   localparam int RSEL_POLL_BIT = 2;

   localparam logic [2:0] CMD_ROT_AEOI_CLR = 3'h0;
   localparam logic [2:0] CMD_NS_EOI       = 3'h1;
   localparam logic [2:0] CMD_SP_EOI       = 3'h3;
   localparam logic [2:0] CMD_ROT_AEOI_SET = 3'h4;
   localparam logic [2:0] CMD_ROT_NS       = 3'h5;
   localparam logic [2:0] CMD_SET_PRIO     = 3'h6;
   localparam logic [2:0] CMD_ROT_SP       = 3'h7;

   localparam logic [1:0] RSEL_ISR       = 2'h3;
   localparam logic [2:0] CASC_LINE      = 3'h2;
   localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MASK_RESET   = 8'hFF;
   localparam logic [2:0] LOWEST_RESET = 3'h7;
   localparam logic [2:0] RSEL_RESET   = 3'h2;

   // ------------------------------------------------------------
   // input routing: jumpered lines and their external candidate
   // external vector is {frontplane[2:0], backplane[4:0]}
   // ------------------------------------------------------------
   localparam int         NUM_JMP = 8;
   localparam logic [3:0] JMP_LINE [NUM_JMP] = '{4'h1, 4'h5, 4'h6, 4'h7,
                                                 4'h8, 4'h9, 4'hD, 4'hE};
   localparam logic [2:0] JMP_EXT  [NUM_JMP] = '{3'h1, 3'h4, 3'h2, 3'h5,
                                                 3'h6, 3'h0, 3'h7, 3'h3};

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CDIC_READY,
      CDIC_WAIT_VB,
      CDIC_WAIT_CASC,
      CDIC_WAIT_MODE
   } cdic_init_t;

   typedef struct packed {
      cdic_init_t  st;
      logic [7:0]  mask;
      logic [7:0]  in_service_flags;
      logic [2:0]  lowest;
      logic [4:0]  vbase;
      logic [7:0]  casc;
      logic        aeoi;
      logic        rot_aeoi;
      logic        level;
      logic        sngl;
      logic        ic4;
      logic [2:0]  rsel;
   } cdic_ctl_t;

   localparam cdic_ctl_t CTL_RESET = '{st: CDIC_READY, mask: MASK_RESET, in_service_flags: 8'h00,
                                      lowest: LOWEST_RESET, vbase: 5'h00,
                                      casc: 8'h00, aeoi: 1'h0, rot_aeoi: 1'h0,
                                      level: 1'h0, sngl: 1'h0, ic4: 1'h0,
                                      rsel: RSEL_RESET};

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // highest-priority set bit: {found, level}; lowest holds the weakest level
   function automatic logic [3:0] cdic_resolve(input logic [7:0] req,
                                               input logic [2:0] lowest);
      logic [3:0] res;
      logic [2:0] lv;
      res = 4'h0;
      lv  = 3'h0;
      for (int i = 8; i >= 1; i--)
      begin
         lv = lowest + 3'(i);
         if (req[lv])
            res = {1'b1, lv};
      end
      return res;
   endfunction

   // 0 is the strongest rank
   function automatic logic [2:0] cdic_rank(input logic [2:0] lv,
                                            input logic [2:0] lowest);
      return 3'(lv - lowest - 3'h1);
   endfunction

   function automatic logic cdic_hit(input logic [15:0] addr,
                                     input logic [15:0] base);
      return addr[15:1] == base[15:1];
   endfunction

endpackage

// [hdl/cdic_req_frontend.sv]
// request front end: inversion, jumper selection and the request latch
// assumes jumper selects are static and all inputs synchronous to clock_in
module cdic_req_frontend
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // request sources
   input  wire logic [4:0]  backplane_irq_n_in,
   input  wire logic [2:0]  frontplane_irq_n_in,
   input  wire logic        timer0_irq_in,
   input  wire logic [15:0] local_irq_in,
   input  wire logic [7:0]  jumper_sel_in,
   // to the controller core
   cdic_req_if.fe           rq
);

   logic [7:0]  ext_w;
   logic [15:0] raw_w;
   logic [15:0] prev_r;
   logic [15:0] prev_nxt;
   logic [15:0] latch_r;
   logic [15:0] latch_nxt;

   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------
   always_comb
   begin
      ext_w = ~{frontplane_irq_n_in, backplane_irq_n_in}; // R06
      raw_w = local_irq_in;
      raw_w[0] = timer0_irq_in; // R16
      raw_w[cdic_pkg::CASC_LINE] = rq.casc_int; // R15
      for (int j = 0; j < cdic_pkg::NUM_JMP; j++)
      begin
         raw_w[cdic_pkg::JMP_LINE[j]] = jumper_sel_in[j] ?
            local_irq_in[cdic_pkg::JMP_LINE[j]] : ext_w[cdic_pkg::JMP_EXT[j]]; // R07
      end
   end

   // ------------------------------------------------------------
   // request latch
   // ------------------------------------------------------------
   always_comb
   begin
      prev_nxt = raw_w;
      for (int l = 0; l < 16; l++)
      begin
         if (rq.level_mode[l / 8]) // R14
            latch_nxt[l] = raw_w[l]; // R04
         else if (raw_w[l] && !prev_r[l])
            latch_nxt[l] = 1'b1; // R04
         else if (rq.ack_clr[l])
            latch_nxt[l] = 1'b0;
         else
            latch_nxt[l] = latch_r[l];
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         prev_r  <= 16'h0000;
         latch_r <= 16'h0000;
      end
      else
      begin
         prev_r  <= prev_nxt;
         latch_r <= latch_nxt;
      end
   end

   assign rq.req_latch = latch_r;

endmodule

// [hdl/cdic_req_if.sv]
// carrier between the controller core and the request front end
// assumes one clock domain, driven inside the top module
interface cdic_req_if;
   logic [1:0]  level_mode;
   logic [15:0] ack_clr;
   logic        casc_int;
   logic [15:0] req_latch;

   modport fe   (input level_mode, input ack_clr, input casc_int, output req_latch);
   modport core (output level_mode, output ack_clr, output casc_int, input req_latch);
endinterface

// [hdl/cdic_top.sv]
// cascaded pair of programmable interrupt controllers, 15 request inputs
// assumes the cpu's port bus strobes are single-cycle and synchronous

// How it works
// (R01) master plus slave give 15 requests
// (R02) unmasked pending raises interrupt, supplies vector
// (R03) every input has its own mask
// (R04) level or edge recognition per programmed mode
// (R05) fixed or rotating priority by command
// (R06) backplane and frontplane requests inverted first
// (R07) jumper picks one of two sources
// (R08) master at 20h, slave at A0h
// (R09) offset 0 status/commands, offset 1 mask/init
// (R10) four init, three command, three status registers
// (R11) no cascade onto the backplane bus
// (R12) software writes words one to three first
// (R13) last command-three low bits pick status
// (R14) trigger mode covers a whole controller
// (R15) slave drives master line 2, gives vector
// (R16) master line 0 is timer 0
module cdic_top
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // cpu port bus
   input  wire logic [15:0] io_addr_in,
   input  wire logic [7:0]  io_wdata_in,
   input  wire logic        io_wr_in,
   input  wire logic        io_rd_in,
   output logic      [7:0]  io_rdata_out,
   // cpu interrupt
   input  wire logic        inta_in,
   output logic             int_out,
   output logic      [7:0]  vector_out,
   // request sources
   input  wire logic [4:0]  backplane_irq_n_in,
   input  wire logic [2:0]  frontplane_irq_n_in,
   input  wire logic        timer0_irq_in,
   input  wire logic [15:0] local_irq_in,
   input  wire logic [7:0]  jumper_sel_in
);

   cdic_req_if rq ();

   logic        int_w   [2];
   logic [2:0]  lvl_w   [2];
   logic        ack_w   [2];
   logic [7:0]  vec_w   [2];
   logic [7:0]  rd_w    [2];
   logic        hit_w   [2];
   logic        level_w [2];
   logic [7:0]  clr_w   [2];
   logic        casc_en_w;
   logic        casc_win_w;
   logic [7:0]  vector_r;
   logic [7:0]  vector_nxt;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;

   cdic_req_frontend u_frontend
   (
      .clock_in            (clock_in),
      .rst_in              (rst_in),
      .backplane_irq_n_in  (backplane_irq_n_in),
      .frontplane_irq_n_in (frontplane_irq_n_in),
      .timer0_irq_in       (timer0_irq_in),
      .local_irq_in        (local_irq_in),
      .jumper_sel_in       (jumper_sel_in),
      .rq                  (rq.fe)
   );

   // ------------------------------------------------------------
   // cascade wiring
   // ------------------------------------------------------------
   assign rq.casc_int   = int_w[1]; // R15
   assign rq.level_mode = {level_w[1], level_w[0]}; // R14
   assign rq.ack_clr    = {clr_w[1], clr_w[0]};
   // slave answers only through the local master, never the backplane
   assign casc_win_w    = int_w[0] && lvl_w[0] == cdic_pkg::CASC_LINE && casc_en_w; // R11
   assign ack_w[0]      = inta_in;
   assign ack_w[1]      = inta_in && casc_win_w; // R15

   // ------------------------------------------------------------
   // one controller per generate pass, 0 master, 1 slave
   // ------------------------------------------------------------
   for (genvar c = 0; c < 2; c++)
   begin : g_pic
      cdic_pkg::cdic_ctl_t cur_r;
      cdic_pkg::cdic_ctl_t cur_nxt;
      logic [7:0]          irr_w;
      logic [3:0]          req_top_w;
      logic [3:0]          isr_top_w;
      logic [2:0]          eoi_lvl;
      logic [7:0]          clr;
      logic                wr_cmd;
      logic                wr_data;
      logic [15:0]         base;

      assign base      = (c == 0) ? cdic_pkg::MASTER_BASE : cdic_pkg::SLAVE_BASE; // R08
      assign hit_w[c]  = cdic_pkg::cdic_hit(io_addr_in, base); // R08
      assign wr_cmd    = io_wr_in && hit_w[c] && io_addr_in[0] == cdic_pkg::OFS_CMD; // R09
      assign wr_data   = io_wr_in && hit_w[c] && io_addr_in[0] == cdic_pkg::OFS_DATA; // R09
      assign irr_w     = rq.req_latch[c * 8 +: 8]; // R01
      assign req_top_w = cdic_pkg::cdic_resolve(irr_w & ~cur_r.mask, cur_r.lowest); // R03
      assign isr_top_w = cdic_pkg::cdic_resolve(cur_r.in_service_flags, cur_r.lowest);
      assign level_w[c] = cur_r.level;
      assign lvl_w[c]  = req_top_w[2:0];
      // nested: a request must outrank everything in service
      assign int_w[c]  = cur_r.st == cdic_pkg::CDIC_READY && req_top_w[3] &&
                         (!isr_top_w[3] || cdic_pkg::cdic_rank(req_top_w[2:0], cur_r.lowest)
                          < cdic_pkg::cdic_rank(isr_top_w[2:0], cur_r.lowest)); // R02
      assign vec_w[c]  = {cur_r.vbase, int_w[c] ? req_top_w[2:0]
                                                : cdic_pkg::SPURIOUS_LEVEL}; // R02
      assign clr_w[c]  = clr;

      // status readback, selected by the last status-select command
      always_comb
      begin
         if (io_addr_in[0] == cdic_pkg::OFS_DATA)
            rd_w[c] = cur_r.mask; // R09
         else if (cur_r.rsel[cdic_pkg::RSEL_POLL_BIT])
            rd_w[c] = {int_w[c], 4'h0, req_top_w[2:0]}; // R13
         else if (cur_r.rsel[1:0] == cdic_pkg::RSEL_ISR)
            rd_w[c] = cur_r.in_service_flags; // R13
         else
            rd_w[c] = irr_w; // R13
      end

      always_comb
      begin
         cur_nxt = cur_r;
         clr     = 8'h00;
         eoi_lvl = isr_top_w[2:0];
         if (c == 1)
            cur_nxt.casc = 8'h00;
         // acknowledge: mark in service unless aeoi is set, consume edge request
         if (ack_w[c] && int_w[c])
         begin
            clr[req_top_w[2:0]] = 1'b1;
            if (!cur_r.aeoi)
               cur_nxt.in_service_flags[req_top_w[2:0]] = 1'b1;
            else if (cur_r.rot_aeoi)
               cur_nxt.lowest = req_top_w[2:0]; // R05
         end
         if (wr_cmd && io_wdata_in[cdic_pkg::INIT_WORD_ONE_SEL_BIT])
         begin
            // init word one restarts the sequence, R12 relies on the rest
            cur_nxt       = cdic_pkg::CTL_RESET; // R10
            cur_nxt.mask  = 8'h00;
            cur_nxt.st    = cdic_pkg::CDIC_WAIT_VB; // R12
            cur_nxt.level = io_wdata_in[cdic_pkg::INIT_WORD_ONE_LTIM_BIT]; // R04
            cur_nxt.sngl  = io_wdata_in[cdic_pkg::INIT_WORD_ONE_SNGL_BIT];
            cur_nxt.ic4   = io_wdata_in[cdic_pkg::INIT_WORD_ONE_IC4_BIT];
         end
         else if (wr_cmd && io_wdata_in[cdic_pkg::STATUS_SELECT_COMMAND_SEL_BIT])
            cur_nxt.rsel = io_wdata_in[2:0]; // R13
         else if (wr_cmd)
         begin
            if (io_wdata_in[6])
               eoi_lvl = io_wdata_in[2:0];
            case (io_wdata_in[7:5])
               cdic_pkg::CMD_NS_EOI, cdic_pkg::CMD_SP_EOI:
                  cur_nxt.in_service_flags[eoi_lvl] = 1'b0;
               cdic_pkg::CMD_ROT_NS, cdic_pkg::CMD_ROT_SP:
               begin
                  cur_nxt.in_service_flags[eoi_lvl] = 1'b0;
                  cur_nxt.lowest       = eoi_lvl; // R05
               end
               cdic_pkg::CMD_SET_PRIO:
                  cur_nxt.lowest = io_wdata_in[2:0]; // R05
               cdic_pkg::CMD_ROT_AEOI_SET:
                  cur_nxt.rot_aeoi = 1'b1; // R05
               cdic_pkg::CMD_ROT_AEOI_CLR:
                  cur_nxt.rot_aeoi = 1'b0;
               default:
                  cur_nxt.rot_aeoi = cur_nxt.rot_aeoi;
            endcase
         end
         else if (wr_data)
         begin
            case (cur_r.st)
               cdic_pkg::CDIC_WAIT_VB:
               begin
                  cur_nxt.vbase = io_wdata_in[7:3];
                  cur_nxt.st    = !cur_r.sngl ? cdic_pkg::CDIC_WAIT_CASC :
                                  cur_r.ic4 ? cdic_pkg::CDIC_WAIT_MODE :
                                  cdic_pkg::CDIC_READY;
               end
               cdic_pkg::CDIC_WAIT_CASC:
               begin
                  if (c == 0)
                     cur_nxt.casc = io_wdata_in;
                  cur_nxt.st = cur_r.ic4 ? cdic_pkg::CDIC_WAIT_MODE : cdic_pkg::CDIC_READY;
               end
               cdic_pkg::CDIC_WAIT_MODE:
               begin
                  cur_nxt.aeoi = io_wdata_in[cdic_pkg::INIT_WORD_MODE_AEOI_BIT];
                  cur_nxt.st   = cdic_pkg::CDIC_READY;
               end
               default:
                  cur_nxt.mask = io_wdata_in; // R03
            endcase
         end
      end

      always_ff @(posedge clock_in)
      begin
         if (rst_in)
            cur_r <= cdic_pkg::CTL_RESET;
         else
            cur_r <= cur_nxt;
      end
   end

   assign casc_en_w = g_pic[0].cur_r.casc[cdic_pkg::CASC_LINE]; // R15

   // ------------------------------------------------------------
   // vector and read data
   // ------------------------------------------------------------
   always_comb
   begin
      vector_nxt = vector_r;
      if (inta_in)
         vector_nxt = casc_win_w ? vec_w[1] : vec_w[0]; // R15
      rdata_nxt = rdata_r;
      if (io_rd_in)
         rdata_nxt = hit_w[0] ? rd_w[0] : hit_w[1] ? rd_w[1] : 8'h00; // R09
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         vector_r <= 8'h00;
         rdata_r  <= 8'h00;
      end
      else
      begin
         vector_r <= vector_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   assign int_out      = int_w[0]; // R02
   assign vector_out   = vector_r;
   assign io_rdata_out = rdata_r;

endmodule

// [verif/cdic_host_model.sv]
// host cpu model: port bus cycles, acknowledge and controller setup
// assumes the device samples on the rising edge of clock_in
module cdic_host_model
(
   // clock
   input  wire logic        clock_in,
   // port bus
   output logic      [15:0] io_addr_out,
   output logic      [7:0]  io_wdata_out,
   output logic             io_wr_out,
   output logic             io_rd_out,
   input  wire logic [7:0]  io_rdata_in,
   // interrupt acknowledge
   output logic             inta_out,
   input  wire logic [7:0]  vector_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      io_addr_out  = 16'h0000;
      io_wdata_out = 8'h00;
      io_wr_out    = 1'b0;
      io_rd_out    = 1'b0;
      inta_out     = 1'b0;
   end

   // released data lines show the inverse of the last value
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_in);
      #2;
      io_addr_out  = a;
      io_wdata_out = d;
      io_wr_out    = 1'b1;
      @(posedge clock_in);
      #2;
      io_wr_out    = 1'b0;
      io_wdata_out = ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock_in);
      #2;
      io_addr_out = a;
      io_rd_out   = 1'b1;
      @(posedge clock_in);
      #2;
      io_rd_out   = 1'b0;
      d           = io_rdata_in;
   endtask

   task automatic ack(output logic [7:0] v);
      @(posedge clock_in);
      #2;
      inta_out = 1'b1;
      @(posedge clock_in);
      #2;
      inta_out = 1'b0;
      @(posedge clock_in);
      #2;
      v = vector_in;
   endtask

   // words one, two and three always, word four never needed here
   task automatic init(input logic [15:0] b, input logic [7:0] w1,
                       input logic [7:0] vb, input logic [7:0] cs);
      wr(b, w1);
      wr(b | 16'h0001, vb);
      wr(b | 16'h0001, cs);
   endtask
endmodule

// [verif/cdic_top_sva.sv]
// concurrent checks on the ports of the cascaded interrupt controller
// assumes one clock domain and the synchronous active-high reset
module cdic_top_chk
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // cpu port bus
   input  wire logic [15:0] io_addr_in,
   input  wire logic [7:0]  io_wdata_in,
   input  wire logic        io_wr_in,
   input  wire logic        io_rd_in,
   input  wire logic [7:0]  io_rdata_out,
   // cpu interrupt
   input  wire logic        inta_in,
   input  wire logic        int_out,
   input  wire logic [7:0]  vector_out,
   // request sources
   input  wire logic [4:0]  backplane_irq_n_in,
   input  wire logic [2:0]  frontplane_irq_n_in,
   input  wire logic        timer0_irq_in,
   input  wire logic [15:0] local_irq_in,
   input  wire logic [7:0]  jumper_sel_in
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic [32:0] stim_w;
   logic [32:0] prev_r;
   logic [1:0]  quiet_r;
   logic [1:0]  quiet_nxt;
   logic        poll_r;
   logic        poll_nxt;
   logic        mapped_w;
   logic        cmd_wr_w;
   assign stim_w   = {timer0_irq_in, local_irq_in, backplane_irq_n_in,
                      frontplane_irq_n_in, jumper_sel_in};
   assign mapped_w = io_addr_in[15:1] == 15'h0010 || io_addr_in[15:1] == 15'h0050;
   assign cmd_wr_w = io_wr_in && io_addr_in == 16'h0020;

   // counts quiet edges; a cascaded request needs two edges to reach the pin
   always_comb
   begin
      quiet_nxt = (quiet_r == 2'h3) ? 2'h3 : quiet_r + 2'h1;
      if (stim_w != prev_r || io_wr_in || inta_in)
         quiet_nxt = 2'h0;
      poll_nxt = poll_r;
      if (cmd_wr_w && io_wdata_in[4])
         poll_nxt = 1'b0;
      else if (cmd_wr_w && io_wdata_in[3])
         poll_nxt = io_wdata_in[2];
   end

   always_ff @(posedge clock_in)
   begin
      prev_r  <= stim_w;
      quiet_r <= rst_in ? 2'h0 : quiet_nxt;
      poll_r  <= rst_in ? 1'b0 : poll_nxt;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_rst_out;
      $fell(rst_in) |-> int_out == 1'b0 && vector_out == 8'h00 && io_rdata_out == 8'h00;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");

   property p_rd_hold;
      !io_rd_in |=> $stable(io_rdata_out);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

   property p_unmapped_rd;
      io_rd_in && !mapped_w |=> io_rdata_out == 8'h00;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

   property p_vec_hold;
      !inta_in && !$past(inta_in) |=> $stable(vector_out);
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector moved without ack");

   property p_init_quiet;
      cmd_wr_w && io_wdata_in[4] |=> !int_out;
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("interrupt during init");

   property p_poll_zero;
      poll_r && io_rd_in && io_addr_in == 16'h0020 |=> io_rdata_out[6:3] == 4'h0;
   endproperty
   a_poll_zero: assert property (p_poll_zero) else $error("poll word padding set");

   property p_poll_int;
      poll_r && io_rd_in && io_addr_in == 16'h0020 |=> io_rdata_out[7] == $past(int_out);
   endproperty
   a_poll_int: assert property (p_poll_int) else $error("poll word flag wrong");

   property p_int_steady;
      quiet_r == 2'h3 |-> $stable(int_out);
   endproperty
   a_int_steady: assert property (p_int_steady) else $error("interrupt moved without cause");
endmodule

bind cdic_top cdic_top_chk u_chk (.clock_in, .rst_in, .io_addr_in, .io_wdata_in, .io_wr_in,
   .io_rd_in, .io_rdata_out, .inta_in, .int_out, .vector_out, .backplane_irq_n_in,
   .frontplane_irq_n_in, .timer0_irq_in, .local_irq_in, .jumper_sel_in);

// [verif/cdic_top_tb_top.sv]
// testbench for the cascaded interrupt controller
// assumes the host model and the bound checker are compiled with it
module cdic_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock_in;
   logic        rst_in;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata;
   logic        io_wr;
   logic        io_rd;
   logic [7:0]  io_rdata;
   logic        inta;
   logic        int_o;
   logic [7:0]  vector;
   logic [4:0]  bp_n = 5'h1F;
   logic [2:0]  fp_n = 3'h7;
   logic        timer0 = 1'b0;
   logic [15:0] local_irq = 16'h0000;
   logic [7:0]  jumper = 8'h00;
   int          error_cnt = 0;
   int          compares = 0;

   cdic_top dut (.clock_in(clock_in), .rst_in(rst_in), .io_addr_in(io_addr),
      .io_wdata_in(io_wdata), .io_wr_in(io_wr), .io_rd_in(io_rd), .io_rdata_out(io_rdata),
      .inta_in(inta), .int_out(int_o), .vector_out(vector), .backplane_irq_n_in(bp_n),
      .frontplane_irq_n_in(fp_n), .timer0_irq_in(timer0), .local_irq_in(local_irq),
      .jumper_sel_in(jumper));

   cdic_host_model host (.clock_in(clock_in), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
      .io_wr_out(io_wr), .io_rd_out(io_rd), .io_rdata_in(io_rdata), .inta_out(inta),
      .vector_in(vector));

   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL %0t %s: got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, exp, msg);
   endtask

   task automatic ackc(input logic [7:0] exp);
      logic [7:0] v;
      host.ack(v);
      chk(v, exp, "vector");
   endtask

   task automatic wait_int(input logic e);
      for (int i = 0; i < 8 && int_o !== e; i++)
      begin
         @(posedge clock_in);
         #2;
      end
      chk({7'h00, int_o}, {7'h00, e}, "interrupt line");
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // clock, reset, watchdog
   // ----------------------------------------
   initial
   begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end

   initial
   begin
      repeat (20000) @(posedge clock_in);
      error_cnt++;
      $display("FAIL %0t run timed out", $time);
      end_of_test();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      rst_in = 1'b1;
      repeat (12) @(posedge clock_in);
      #2;
      rst_in = 1'b0;
      rdc(16'h0021, 8'hFF, "master mask reset");
      rdc(16'h00A1, 8'hFF, "slave mask reset");
      rdc(16'h0030, 8'h00, "unmapped read");
      rdc(16'h0020, 8'h00, "request latch idle");
      $display("test reset done");
      host.init(16'h0020, 8'h10, 8'h40, 8'h04);
      host.init(16'h00A0, 8'h10, 8'h70, 8'h02);
      host.wr(16'h0021, 8'h5A);
      rdc(16'h0021, 8'h5A, "mask readback");
      host.wr(16'h0021, 8'h00);
      wait_int(1'b0);
      $display("test init done");
      timer0 = 1'b1;
      wait_int(1'b1);
      ackc(8'h40);
      host.wr(16'h0020, 8'h0B);
      rdc(16'h0020, 8'h01, "in service");
      host.wr(16'h0020, 8'h20);
      wait_int(1'b0);
      rdc(16'h0020, 8'h00, "service ended");
      timer0 = 1'b0;
      $display("test edge done");
      host.wr(16'h0021, 8'h01);
      timer0 = 1'b1;
      repeat (4) @(posedge clock_in);
      #2;
      chk({7'h00, int_o}, 8'h00, "masked line");
      host.wr(16'h0021, 8'h00);
      wait_int(1'b1);
      ackc(8'h40);
      host.wr(16'h0020, 8'h20);
      timer0 = 1'b0;
      $display("test mask done");
      for (int s = 0; s < 2; s++)
      begin
         jumper = (s == 1) ? 8'h20 : 8'h00;
         if (s == 1)
            local_irq[9] = 1'b1;
         else
            bp_n[0] = 1'b0;
         wait_int(1'b1);
         ackc(8'h71);
         host.wr(16'h00A0, 8'h20);
         host.wr(16'h0020, 8'h20);
         local_irq[9] = 1'b0;
         bp_n[0] = 1'b1;
         repeat (3) @(posedge clock_in);
         #2;
      end
      $display("test cascade done");
      for (int p = 0; p < 2; p++)
      begin
         if (p == 1)
            host.wr(16'h0020, 8'hC3);
         local_irq[4:3] = 2'h3;
         wait_int(1'b1);
         ackc((p == 1) ? 8'h44 : 8'h43);
         host.wr(16'h0020, 8'h20);
         wait_int(1'b1);
         ackc((p == 1) ? 8'h43 : 8'h44);
         host.wr(16'h0020, 8'h20);
         local_irq[4:3] = 2'h0;
         repeat (3) @(posedge clock_in);
         #2;
      end
      host.wr(16'h0020, 8'hC7);
      $display("test priority done");
      host.init(16'h0020, 8'h18, 8'h40, 8'h04);
      local_irq[3] = 1'b1;
      wait_int(1'b1);
      host.wr(16'h0020, 8'h0C);
      rdc(16'h0020, 8'h83, "poll word");
      ackc(8'h43);
      host.wr(16'h0020, 8'h20);
      wait_int(1'b1);
      local_irq[3] = 1'b0;
      wait_int(1'b0);
      $display("test level done");
      end_of_test();
   end
endmodule
